// [hdl/fciu_stall_counter.sv]
`timescale 1ns/1ps
// down-counter holding the remaining decode stall cycles
// assumes a synchronised active-low reset from the top
module fciu_stall_counter
  import fciu_pkg::*;
(
  input  wire logic   clk_i,     // core clock
  input  wire logic   nrst_i,    // synchronised reset, active low
  fciu_stall_if.cnt   stall_bus  // control from the interlock
);
  logic [STALL_W-1:0] count_reg;  // remaining cycles
  logic [STALL_W-1:0] count_next; // next remaining cycles

  ////////////////////////////////////////////////////////////////////////
  // next count: clear beats load, load beats the decrement
  always_comb begin
    count_next = count_reg;
    if (stall_bus.clear) begin
      count_next = STALL_NONE;
    end else if (stall_bus.load) begin
      count_next = stall_bus.load_val;
    end else if (count_reg != STALL_NONE) begin
      count_next = count_reg - STALL_ONE;
    end
  end

  // register only
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg <= STALL_NONE;
    end else begin
      count_reg <= count_next;
    end
  end

  assign stall_bus.count = count_reg;
endmodule

// [hdl/fciu_top.sv]
`timescale 1ns/1ps
// decode-stage flow-control interlock: lengthens decode on loop-end
// boundary cases, false conditions, interrupt aborts and degenerate loops
// assumes the core holds each decode slot stable until dec_accept_o and
// that program code keeps the loop-end sequence restrictions
module fciu_top
  import fciu_pkg::*;
(
  input  wire logic              clk_i,               // core clock 50 MHz
  input  wire logic              nrst_i,              // async reset, low
  input  wire logic              dec_valid_i,         // slot holds an instr
  input  wire logic [ADDR_W-1:0] dec_pc_i,            // address of the slot
  input  wire logic              dec_jump_i,          // taken jump of any type
  input  wire logic              dec_rti_i,           // interrupt return
  input  wire logic [ADDR_W-1:0] dec_target_i,        // jump/return target
  input  wire logic              dec_cond_false_i,    // condition false
  input  wire logic              dec_loop_i,          // hardware loop start
  input  wire logic              dec_loop_one_i,      // loop body one word
  input  wire logic              dec_loop_zero_i,     // loop count zero
  input  wire logic              dec_rpt_i,           // single_repeat_instr
  input  wire logic              dec_rpt_zero_i,      // repeat count zero
  input  wire logic              irq_abort_i,         // interrupt abort req
  input  wire logic              loop_active_flag_i,  // loop in progress
  input  wire logic [ADDR_W-1:0] loop_end_address_i,  // loop end address
  output logic                   dec_hold_o,          // decode stalled
  output logic                   dec_accept_o,        // slot accepted
  output logic                   bubble_o,            // execute gets a nop
  output logic                   hole_o,              // abort hole cycle
  output logic                   abort_taken_o        // abort accepted now
);
  ////////////////////////////////////////////////////////////////////////
  // reset release through two flops; first flop feeds only the second
  logic rst_meta_reg; // first stage
  logic rst_n_reg;    // synchronised reset used by the design

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  fciu_stall_if stall_bus ();         // carrier to the counter
  logic               armed_reg;      // current slot already charged
  logic               armed_next;     // next charged flag
  logic               hole_reg;       // abort hole in progress
  logic               hole_next;      // next hole flag
  logic [STALL_W-1:0] arm_reg;        // stall owed after loop end instr
  logic [STALL_W-1:0] arm_next;       // next owed stall
  logic [STALL_W-1:0] pend_reg;       // stall owed by the next slot
  logic [STALL_W-1:0] pend_next;      // next owed stall
  logic [STALL_W-1:0] own_ext;        // lengthening of the slot itself
  logic [STALL_W-1:0] total;          // all stall charged to this slot
  logic               present_new;    // slot seen for the first time
  logic               abort_take;     // abort of a lengthened decode
  logic [ADDR_W-1:0]  end_m1;         // loop end minus one
  logic               hit_end;        // target is the loop end
  logic               hit_end_m1;     // target is loop end minus one

  fciu_stall_counter u_counter (
    .clk_i     (clk_i),
    .nrst_i    (rst_n_reg),
    .stall_bus (stall_bus)
  );

  assign end_m1     = loop_end_address_i - END_M1_OFFSET;
  assign hit_end    = loop_active_flag_i && (dec_target_i == loop_end_address_i);
  assign hit_end_m1 = loop_active_flag_i && (dec_target_i == end_m1);

  ////////////////////////////////////////////////////////////////////////
  // own lengthening of the slot; independent causes add
  always_comb begin
    own_ext = STALL_NONE;
    if (dec_loop_i) begin
      if (dec_loop_one_i) begin
        own_ext = own_ext + LOOP_ONE_STALL;
      end
      if (dec_loop_zero_i) begin
        own_ext = own_ext + LOOP_ZERO_STALL;
      end
    end
    if (dec_rpt_i && dec_rpt_zero_i) begin
      own_ext = own_ext + RPT_ZERO_STALL;
    end
  end

  // stalls owed and own stalls add together
  assign total = pend_reg + own_ext;

  ////////////////////////////////////////////////////////////////////////
  // hold and accept; a hold cycle issues a bubble so nothing changes
  assign present_new = dec_valid_i && !armed_reg && !hole_reg;

  always_comb begin
    if (present_new) begin
      dec_hold_o = (total != STALL_NONE);
    end else begin
      dec_hold_o = dec_valid_i && !hole_reg &&
                   (stall_bus.count != STALL_NONE);
    end
  end

  // abort only while a decode is being lengthened
  assign abort_take    = irq_abort_i && dec_hold_o;
  assign abort_taken_o = abort_take;
  assign dec_accept_o  = dec_valid_i && !hole_reg && !dec_hold_o;
  assign hole_o        = hole_reg;
  // every stalled or hole cycle is an empty pipeline slot
  assign bubble_o      = dec_hold_o || hole_reg;

  // counter control: charge on first sight, minus the current cycle
  assign stall_bus.load     = present_new && !abort_take;
  assign stall_bus.load_val = (total != STALL_NONE) ? total - STALL_ONE
                                                    : STALL_NONE;
  assign stall_bus.clear    = abort_take;

  ////////////////////////////////////////////////////////////////////////
  // slot bookkeeping and abort hole
  always_comb begin
    armed_next = armed_reg;
    hole_next  = 1'b0;
    if (abort_take) begin
      // single hole, slot dropped for the vector
      armed_next = 1'b0;
      hole_next  = 1'b1;
    end else if (dec_accept_o) begin
      armed_next = 1'b0;
    end else if (present_new) begin
      armed_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      armed_reg <= 1'b0;
      hole_reg  <= 1'b0;
    end else begin
      armed_reg <= armed_next;
      hole_reg  <= hole_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // owed stalls: loop-end arming and next-slot debt
  always_comb begin
    arm_next  = arm_reg;
    pend_next = pend_reg;
    // debt is consumed when the next slot is charged
    if (stall_bus.load) begin
      pend_next = STALL_NONE;
    end
    if (dec_accept_o) begin
      // the loop end instr hands the arming to its follower
      if ((dec_pc_i == loop_end_address_i) && (arm_reg != STALL_NONE)) begin
        pend_next = pend_next + arm_reg;
        arm_next  = STALL_NONE;
      end
      // false condition delays the next slot
      if (dec_cond_false_i) begin
        pend_next = pend_next + COND_FALSE_STALL;
      end
      if (dec_jump_i) begin
        if (hit_end) begin
          // two cycles after the loop end
          arm_next = JMP_END_STALL;
        end else if (hit_end_m1) begin
          // one cycle after the loop end
          arm_next = JMP_END_M1_STALL;
        end
      end else if (dec_rti_i) begin
        if (hit_end) begin
          // two cycles after the loop end
          arm_next = RTI_END_STALL;
        end else if (hit_end_m1) begin
          // one cycle after the loop end
          arm_next = RTI_END_M1_STALL;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      arm_reg  <= STALL_NONE;
      pend_reg <= STALL_NONE;
    end else begin
      arm_reg  <= arm_next;
      pend_reg <= pend_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_quiet;
    pend_reg == STALL_NONE && !irq_abort_i;
  endsequence

  sequence s_hole;
    hole_o ##1 !hole_o;
  endsequence

  AST_LOOP_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    (present_new && dec_loop_i && dec_loop_zero_i && !dec_loop_one_i &&
     !dec_rpt_i && !irq_abort_i && pend_reg == STALL_NONE) |->
    (dec_hold_o [*3] ##1 !dec_hold_o) or (##[0:2] abort_take))
    else $error("zero-count loop not held three cycles");

  AST_RPT_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    (present_new && dec_rpt_i && dec_rpt_zero_i && !dec_loop_i) and s_quiet
    |-> dec_hold_o ##1 !dec_hold_o)
    else $error("zero-count repeat not held one cycle");

  AST_LOOP_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    (present_new && dec_loop_i && dec_loop_one_i && !dec_loop_zero_i &&
     !dec_rpt_i) and s_quiet |-> dec_hold_o ##1 !dec_hold_o)
    else $error("one-word loop not held one cycle");

  AST_COND_FALSE: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    (dec_accept_o && dec_cond_false_i) |=>
    pend_reg >= COND_FALSE_STALL)
    else $error("false condition left no stall for the next slot");

  AST_JMP_END: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    (dec_accept_o && dec_jump_i && hit_end) |=>
    arm_reg == JMP_END_STALL)
    else $error("jump to loop end not armed for two");

  AST_RTI_END_M1: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    (dec_accept_o && dec_rti_i && !dec_jump_i && hit_end_m1 && !hit_end) |=>
    arm_reg == RTI_END_M1_STALL)
    else $error("return to loop end minus one not armed for one");

  AST_END_HANDOFF: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    (dec_accept_o && dec_pc_i == loop_end_address_i && !dec_jump_i &&
     !dec_rti_i && arm_reg == JMP_END_STALL) |=>
    pend_reg >= JMP_END_STALL && arm_reg == STALL_NONE)
    else $error("loop end did not pass its stall on");

  AST_ABORT_HOLE: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    abort_take |=> s_hole and !dec_accept_o)
    else $error("interrupt abort did not give exactly one hole");

  AST_BUBBLE: assert property (@(posedge clk_i) disable iff (!rst_n_reg)
    dec_hold_o |-> bubble_o && !dec_accept_o)
    else $error("stalled cycle was not a bubble");
endmodule

// [pkg/fciu_pkg.sv]
// constants shared by the flow-control interlock unit and its stall counter
// assumes one core clock and a decode stage that holds an instruction stable
// until it is accepted
//
// Notes on behaviour
// - jump to loop end: next-after-end waits two
// - jump to end minus one: waits one
// - return to loop end: next-after-end waits two
// - return to end minus one: waits one
// - false conditional flow change delays next one
// - aborted multi-cycle decode: one hole, then vector
// - single-instruction loop body lengthens loop decode
// - zero-count repeat lengthens decode one cycle
// - zero-count loop lengthens decode three cycles
package fciu_pkg;
  localparam int unsigned ADDR_W = 24;           // program address width
  localparam int unsigned STALL_W = 4;           // stall count width
  localparam logic [ADDR_W-1:0] END_M1_OFFSET = 24'h000001; // end minus one
  localparam logic [STALL_W-1:0] JMP_END_STALL = 4'h2;    // jump to end
  localparam logic [STALL_W-1:0] JMP_END_M1_STALL = 4'h1; // jump to end-1
  localparam logic [STALL_W-1:0] RTI_END_STALL = 4'h2;    // return to end
  localparam logic [STALL_W-1:0] RTI_END_M1_STALL = 4'h1; // return to end-1
  localparam logic [STALL_W-1:0] COND_FALSE_STALL = 4'h1; // false condition
  localparam logic [STALL_W-1:0] LOOP_ONE_STALL = 4'h1;  // one-word body
  localparam logic [STALL_W-1:0] RPT_ZERO_STALL = 4'h1;  // repeat count 0
  localparam logic [STALL_W-1:0] LOOP_ZERO_STALL = 4'h3; // loop count 0
  localparam logic [STALL_W-1:0] STALL_NONE = 4'h0;      // no stall
  localparam logic [STALL_W-1:0] STALL_ONE = 4'h1;       // unit step
endpackage

// [pkg/fciu_stall_if.sv]
`timescale 1ns/1ps
// carrier between the interlock control and its down-counter
// assumes both ends share the core clock
interface fciu_stall_if;
  import fciu_pkg::*;
  logic               load;     // take load_val this cycle
  logic [STALL_W-1:0] load_val; // cycles still to hold after this one
  logic               clear;    // drop any remaining stall
  logic [STALL_W-1:0] count;    // remaining stall cycles
  modport ctrl (output load, output load_val, output clear, input count);
  modport cnt  (input load, input load_val, input clear, output count);
endinterface

// [sim/fciu_code_model.sv]
// partner model: program code that fills the decode slot of the interlock
// assumes the bench calls set_loop and issue from one process only
`timescale 1ns/1ps
module fciu_code_model
  import fciu_pkg::*;
(
  input  wire logic              clk_i,         // core clock
  input  wire logic              accept_i,      // slot accepted
  input  wire logic              abort_taken_i, // abort accepted
  output logic                   valid_o,       // slot presented
  output logic [ADDR_W-1:0]      pc_o,          // slot address
  output logic [ADDR_W-1:0]      target_o,      // jump or return target
  output logic [7:0]             kind_o,        // slot kind flags
  output logic                   irq_abort_o,   // abort request
  output logic                   loop_act_o,    // loop in progress
  output logic [ADDR_W-1:0]      loop_end_o     // loop end address
);
  ////////////////////////////////////////////////////////////////////////
  // idle values at time zero, no loop active yet
  initial begin
    valid_o     = 1'b0;
    pc_o        = 24'h000000;
    target_o    = 24'h000000;
    kind_o      = 8'h00;
    irq_abort_o = 1'b0;
    loop_act_o  = 1'b0;
    loop_end_o  = 24'h000000;
  end

  ////////////////////////////////////////////////////////////////////////
  // loop entered cleanly
  task set_loop(input logic [ADDR_W-1:0] la);
    @(posedge clk_i);
    loop_act_o <= 1'b1;
    loop_end_o <= la;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // one slot, held stable until accepted or aborted; the model emits whatever
  // kind the bench passes, so it does not keep forbidden words off a loop end or exit
  // clean loop tail
  task issue(input  logic [ADDR_W-1:0] pc,
             input  logic [ADDR_W-1:0] tgt,
             input  logic [7:0]        kind,
             input  logic [7:0]        abort_at,
             output logic [7:0]        holds,
             output logic              aborted);
    logic done;
    done    = 1'b0;
    holds   = 8'h00;
    aborted = 1'b0;
    @(posedge clk_i);
    valid_o  <= 1'b1;
    pc_o     <= pc;
    target_o <= tgt;
    kind_o   <= kind;
    // bounded wait so a stuck hold cannot hang the model
    while (!done && holds < 8'h14) begin
      @(negedge clk_i);
      if (abort_taken_i === 1'b1) begin
        aborted = 1'b1;
        done    = 1'b1;
      end else if (accept_i === 1'b1) begin
        done = 1'b1;
      end else begin
        holds = holds + 8'h01;
        @(posedge clk_i);
        // abort is only meaningful while the slot is held
        if (holds == abort_at) begin
          irq_abort_o <= 1'b1;
        end
      end
    end
    @(posedge clk_i);
    // released fields show inverted junk, not the last slot
    valid_o     <= 1'b0;
    irq_abort_o <= 1'b0;
    pc_o        <= ~pc;
    target_o    <= ~tgt;
    kind_o      <= ~kind;
  endtask
endmodule

// [sim/testbench.sv]
// self-checking bench for the flow-control interlock top
// assumes the code model drives every decode input of the design
`timescale 1ns/1ps
module testbench;
  import fciu_pkg::*;
  localparam logic [7:0] K_NONE = 8'h00; // plain instruction
  localparam logic [7:0] K_JMP  = 8'h80; // taken jump
  localparam logic [7:0] K_RTI  = 8'h40; // interrupt return
  localparam logic [7:0] K_CF   = 8'h20; // false condition
  localparam logic [7:0] K_LOOP = 8'h10; // loop start
  localparam logic [7:0] K_ONE  = 8'h08; // one-word body
  localparam logic [7:0] K_ZERO = 8'h04; // loop count zero
  localparam logic [7:0] K_RPT  = 8'h02; // single repeat
  localparam logic [7:0] K_RPTZ = 8'h01; // repeat count zero
  localparam logic [ADDR_W-1:0] LOOP_END = 24'h000200; // loop end used here

  logic              clk_i;      // core clock
  logic              nrst_i;     // reset, active low
  logic              valid;      // slot presented
  logic [ADDR_W-1:0] pc;         // slot address
  logic [ADDR_W-1:0] tgt;        // target address
  logic [7:0]        kind;       // slot kind flags
  logic              irq;        // abort request
  logic              lact;       // loop active
  logic [ADDR_W-1:0] lend;       // loop end
  logic              hold;       // decode stalled
  logic              accept;     // slot accepted
  logic              bubble;     // nop to execute
  logic              hole;       // abort hole
  logic              abt;        // abort taken
  logic [7:0]        holds;      // hold cycles seen
  logic              aborted;    // slot was aborted
  int                n_mismatch; // mismatches
  int                num_checks; // comparisons

  ////////////////////////////////////////////////////////////////////////
  // clock and instances
  initial clk_i = 1'b0;
  always #10 clk_i = ~clk_i;

  fciu_code_model code_u (.clk_i(clk_i), .accept_i(accept),
    .abort_taken_i(abt), .valid_o(valid), .pc_o(pc), .target_o(tgt),
    .kind_o(kind), .irq_abort_o(irq), .loop_act_o(lact),
    .loop_end_o(lend));

  fciu_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .dec_valid_i(valid),
    .dec_pc_i(pc), .dec_jump_i(kind[7]), .dec_rti_i(kind[6]),
    .dec_target_i(tgt), .dec_cond_false_i(kind[5]),
    .dec_loop_i(kind[4]), .dec_loop_one_i(kind[3]),
    .dec_loop_zero_i(kind[2]), .dec_rpt_i(kind[1]),
    .dec_rpt_zero_i(kind[0]), .irq_abort_i(irq),
    .loop_active_flag_i(lact), .loop_end_address_i(lend),
    .dec_hold_o(hold), .dec_accept_o(accept), .bubble_o(bubble),
    .hole_o(hole), .abort_taken_o(abt));

  ////////////////////////////////////////////////////////////////////////
  // shared compare, verdict and slot helper
  task check(input string name, input logic [7:0] seen,
             input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task final_report;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // issue one slot and compare its stall length
  task slot(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t,
            input logic [7:0] k, input logic [7:0] exp);
    code_u.issue(a, t, k, 8'h00, holds, aborted);
    check("stall cycles", holds, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task t_own;
    slot(24'h000010, 24'h0, K_LOOP | K_ZERO, 8'h03);
    slot(24'h000011, 24'h0, K_LOOP | K_ONE, 8'h01);
    slot(24'h000012, 24'h0, K_RPT | K_RPTZ, 8'h01);
    slot(24'h000013, 24'h0, K_LOOP | K_ONE | K_ZERO, 8'h04);
    slot(24'h000014, 24'h0, K_RPT, 8'h00);
    slot(24'h000015, 24'h0, K_LOOP, 8'h00);
  endtask

  // false condition owes one cycle to the next slot only
  task t_cond;
    slot(24'h000020, 24'h0, K_CF, 8'h00);
    slot(24'h000021, 24'h0, K_NONE, 8'h01);
    slot(24'h000022, 24'h0, K_NONE, 8'h00);
    slot(24'h000023, 24'h0, K_CF, 8'h00);
    slot(24'h000024, 24'h0, K_LOOP | K_ZERO, 8'h04);
  endtask

  // jump or return to the loop end or one below, a jump two below, then run past the end
  task t_flow;
    for (int i = 0; i < 5; i++) begin
      slot(24'h000100, (i == 4) ? LOOP_END - 24'h2 :
           (i[0] ? LOOP_END - 24'h1 : LOOP_END),
           i[1] ? K_RTI : K_JMP, 8'h00);
      slot(LOOP_END, 24'h0, K_NONE, 8'h00);
      slot(LOOP_END + 24'h1, 24'h0, K_NONE,
           (i == 4) ? 8'h00 : (i[0] ? 8'h01 : 8'h02));
    end
  endtask

  // abort in a held zero-count loop, one hole, then the vector slot
  task t_abort;
    code_u.issue(24'h000030, 24'h0, K_LOOP | K_ZERO, 8'h01, holds,
                 aborted);
    check("abort taken", {7'h00, aborted}, 8'h01);
    check("held before abort", holds, 8'h01);
    @(negedge clk_i);
    check("hole", {7'h00, hole}, 8'h01);
    check("hole bubble", {7'h00, bubble}, 8'h01);
    check("hole no accept", {7'h00, accept}, 8'h00);
    check("hole no hold", {7'h00, hold}, 8'h00);
    slot(24'h000300, 24'h0, K_NONE, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence: two reset cycles, settle, then the scenarios
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    nrst_i     = 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    code_u.set_loop(LOOP_END);
    t_own;
    t_cond;
    t_flow;
    t_abort;
    final_report;
  end

  // watchdog: the scenarios need under a hundred cycles, allow 5000
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
endmodule
